/* File: sdc_cfg.svh */
// Purpose: named constants of the sigma-delta conversion control block
// Assumes: 20 MHz system clock
// Notes:   times in their own unit, cycle counts derived from them
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// ****************************************
// clock and times
// ****************************************
`define SDC_CLK_KHZ       20000
`define SDC_T_CONV_MS     8
`define SDC_T_SETTLE_MS   24
`define SDC_T_WAKE_MS     1
`define SDC_CONV_CYC      (`SDC_T_CONV_MS * `SDC_CLK_KHZ)
`define SDC_SETTLE_CYC    (`SDC_T_SETTLE_MS * `SDC_CLK_KHZ)
`define SDC_WAKE_CYC      (`SDC_T_WAKE_MS * `SDC_CLK_KHZ)
`define SDC_GUARD_CYC     4

// ****************************************
// result coding and serial word
// ****************************************
`define SDC_RES_W         16
`define SDC_STAT_W        8
`define SDC_WORD_W        24
`define SDC_ZERO_CODE     16'h8000
`define SDC_MAX_CODE      16'hffff
`define SDC_MIN_CODE      16'h0000
`define SDC_PAT_BITS      3'h5
`define SDC_BITCNT_W      5
`define SDC_FIFO_DEPTH    8

`endif

/* File: sdc_pkg.sv */
// Purpose: shared types of the sigma-delta conversion control block
// Assumes: nothing
// Notes:   states of the conversion sequencer
package sdc_pkg;
	typedef enum logic [1:0] {
		SDC_OFF,
		SDC_WAKE,
		SDC_SETTLE,
		SDC_RUN
	} sdc_state_t;
endpackage

/* File: sdc_conv_ctrl.sv */
// Purpose: conversion sequencing, power-down/reset, coding and serial readout
// Assumes: filter samples arrive on clk_i; serial clock and power pin are asynchronous
// Notes:   a FIFO of filter samples is drained once per conversion period
`timescale 1ns/1ns
`include "sdc_cfg.svh"

// ****************************************
// sample FIFO
// ****************************************
module sdc_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = `SDC_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// fill side
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	// drain side
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
		$error("sdc_fifo: bad size");
	end

	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rd_q];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ****************************************
// conversion control
// ****************************************
// How it works
// - a conversion completes every 8 ms at a fixed 125 Hz with no rate choice.
// - after any reset the first result appears only after the full 24 ms settling time.
// - every completed conversion overwrites the result, read or not.
// - with power_down_reset_n low everything stops and the data/ready pin floats.
// - power_down_reset_n low resets the sequencer, serial state, filter samples and result.
// - on release the block waits 1 ms for the oscillator before sampling starts.
// - out of power-down the data/ready pin is driven high until the first result.
// - the power-on reset performs the same full reset without host action.
// - results are offset binary, zero input giving the MSB alone.
// - the result is 16 bits, code equal to 2^15 times (ratio plus one).
// - data/ready goes low when a new result is in the output register.
// - a read shifts out 24 bits, the result then eight status bits, on host clock pulses.
// - each result is read once and data/ready returns high after the read.
// - an unread result is withdrawn with the pin high shortly before the next update.
module sdc_conv_ctrl
	import sdc_pkg::*;
#(
	parameter int          SAMPLE_W   = 18,
	parameter int          CONV_CYC   = `SDC_CONV_CYC,
	parameter int          SETTLE_CYC = `SDC_SETTLE_CYC,
	parameter int          WAKE_CYC   = `SDC_WAKE_CYC,
	parameter logic [1:0]  ID_BITS    = 2'h2  // arbitrary value
) (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// power-down/reset pin
	input  wire logic                power_down_reset_n_i,
	// filter samples, signed, full scale at +/- 2^15
	input  wire logic [SAMPLE_W-1:0] sample_i,
	input  wire logic                sample_valid_i,
	output logic                     sample_ready_o,
	// serial link
	input  wire logic                sclk_i,
	output logic                     dout_o,
	output logic                     dout_oe_n_o,
	// status
	output sdc_pkg::sdc_state_t      state_o
);
	import sdc_pkg::*;

	localparam int CW = $clog2(SETTLE_CYC + 1);

	if (SAMPLE_W <= `SDC_RES_W || SAMPLE_W > 31) begin : g_bad_sample_w
		$error("sdc_conv_ctrl: bad SAMPLE_W");
	end
	if (CONV_CYC <= `SDC_GUARD_CYC + 2) begin : g_bad_conv
		$error("sdc_conv_ctrl: CONV_CYC too small");
	end
	if (SETTLE_CYC < 2 || WAKE_CYC < 2 || WAKE_CYC > SETTLE_CYC) begin : g_bad_timing
		$error("sdc_conv_ctrl: bad timing");
	end
	if (SETTLE_CYC < CONV_CYC) begin : g_bad_settle
		$error("sdc_conv_ctrl: settle below period");
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic pd_m_q;
	logic pd_s_q;
	logic sclk_m_q;
	logic sclk_s_q;
	logic sclk_d_q;
	logic sclk_fall;
	logic sclk_rise;
	logic irst;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pd_m_q <= 1'b0;
			pd_s_q <= 1'b0;
		end else begin
			pd_m_q <= power_down_reset_n_i;
			pd_s_q <= pd_m_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_m_q <= 1'b1;
			sclk_s_q <= 1'b1;
			sclk_d_q <= 1'b1;
		end else begin
			sclk_m_q <= sclk_i;
			sclk_s_q <= sclk_m_q;
			sclk_d_q <= sclk_s_q;
		end
	end

	assign sclk_fall = sclk_d_q && !sclk_s_q;
	assign sclk_rise = !sclk_d_q && sclk_s_q;
	assign irst      = rst_i || !pd_s_q;

	// ****************************************
	// conversion sequencer
	// ****************************************
	sdc_state_t      state_q;
	logic [CW-1:0]   cnt_q;
	logic            conv_tick;
	logic            guard;

	assign conv_tick = ((state_q == SDC_SETTLE) && (cnt_q == CW'(SETTLE_CYC - 1)))
	                || ((state_q == SDC_RUN) && (cnt_q == CW'(CONV_CYC - 1)));
	assign guard     = (state_q == SDC_RUN)
	                && (cnt_q >= CW'(CONV_CYC - 1 - `SDC_GUARD_CYC));
	assign state_o   = state_q;

	always_ff @(posedge clk_i) begin
		if (irst) begin
			state_q <= SDC_OFF;
			cnt_q   <= '0;
		end else begin
			unique case (state_q)
				SDC_OFF: begin
					state_q <= SDC_WAKE;
					cnt_q   <= '0;
				end
				SDC_WAKE: begin
					if (cnt_q == CW'(WAKE_CYC - 1)) begin
						state_q <= SDC_SETTLE;
						cnt_q   <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				SDC_SETTLE: begin
					if (conv_tick) begin
						state_q <= SDC_RUN;
						cnt_q   <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				SDC_RUN: begin
					cnt_q <= conv_tick ? '0 : cnt_q + 1'b1;
				end
			endcase
		end
	end

	// ****************************************
	// sample buffer and coding
	// ****************************************
	logic [SAMPLE_W-1:0] fifo_data;
	logic                fifo_valid;
	logic [SAMPLE_W-1:0] hold_q;
	logic [SAMPLE_W-1:0] src;
	logic [SAMPLE_W:0]   sum;
	logic [`SDC_RES_W-1:0] code;
	logic                over;
	logic                under;
	logic [`SDC_RES_W-1:0] result_q;
	logic                err_q;

	sdc_fifo #(
		.WIDTH (SAMPLE_W),
		.DEPTH (`SDC_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (irst),
		.in_data_i   (sample_i),
		.in_valid_i  (sample_valid_i),
		.in_ready_o  (sample_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (conv_tick)
	);

	assign src   = fifo_valid ? fifo_data : hold_q;
	assign sum   = {src[SAMPLE_W-1], src} + (SAMPLE_W+1)'(`SDC_ZERO_CODE);
	assign under = sum[SAMPLE_W];
	assign over  = !sum[SAMPLE_W] && (sum[SAMPLE_W-1:`SDC_RES_W] != '0);
	assign code  = under ? `SDC_MIN_CODE : (over ? `SDC_MAX_CODE : sum[`SDC_RES_W-1:0]);

	always_ff @(posedge clk_i) begin
		if (irst) begin
			hold_q   <= '0;
			result_q <= `SDC_ZERO_CODE;
			err_q    <= 1'b0;
		end else if (conv_tick) begin
			hold_q   <= src;
			result_q <= code;
			err_q    <= under || over;
		end
	end

	// ****************************************
	// serial readout
	// ****************************************
	logic                     avail_q;
	logic [`SDC_BITCNT_W-1:0] bit_q;
	logic [`SDC_WORD_W-1:0]   shift_q;
	logic                     dout_q;
	logic                     done;

	assign done        = sclk_rise && (bit_q == `SDC_BITCNT_W'(`SDC_WORD_W));
	assign dout_o      = dout_q;
	assign dout_oe_n_o = (state_q == SDC_OFF);

	always_ff @(posedge clk_i) begin
		if (irst) begin
			avail_q <= 1'b0;
			bit_q   <= '0;
			shift_q <= '0;
		end else if (conv_tick) begin
			avail_q <= 1'b1;
			bit_q   <= '0;
			shift_q <= {code, 1'b0, 1'b0, under || over, ID_BITS, `SDC_PAT_BITS};
		end else if (guard || done) begin
			avail_q <= 1'b0;
			bit_q   <= '0;
		end else if (avail_q && sclk_fall && (bit_q != `SDC_BITCNT_W'(`SDC_WORD_W))) begin
			bit_q   <= bit_q + 1'b1;
			shift_q <= {shift_q[`SDC_WORD_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge clk_i) begin
		if (irst) begin
			dout_q <= 1'b1;
		end else if (conv_tick) begin
			dout_q <= 1'b0;
		end else if (guard || done || !avail_q) begin
			dout_q <= 1'b1;
		end else if (sclk_fall && (bit_q != `SDC_BITCNT_W'(`SDC_WORD_W))) begin
			dout_q <= shift_q[`SDC_WORD_W-1];
		end
	end

	// ****************************************
	// checks
	// ****************************************
	logic [CW-1:0] since_q;
	logic          ran_q;

	always_ff @(posedge clk_i) begin
		if (irst) begin
			since_q <= '0;
			ran_q   <= 1'b0;
		end else begin
			since_q <= conv_tick ? '0 : since_q + 1'b1;
			ran_q   <= ran_q || conv_tick;
		end
	end

	sequence s_read_end;
		done && !conv_tick;
	endsequence

	sequence s_back_high;
		!avail_q && dout_q ##1 dout_q;
	endsequence

	property p_rate;
		@(posedge clk_i) disable iff (irst) conv_tick && ran_q |-> since_q == CW'(CONV_CYC - 1);
	endproperty
	a_rate: assert property (p_rate) else $error("period not 8 ms");

	property p_first;
		@(posedge clk_i) disable iff (irst)
			conv_tick && !ran_q |-> state_q == SDC_SETTLE && cnt_q == CW'(SETTLE_CYC - 1);
	endproperty
	a_first: assert property (p_first) else $error("first result too early");

	property p_hiz;
		@(posedge clk_i) disable iff (rst_i) $fell(pd_s_q) |=> dout_oe_n_o;
	endproperty
	a_hiz: assert property (p_hiz) else $error("pin driven in power-down");

	property p_reset;
		@(posedge clk_i) disable iff (rst_i) !pd_s_q |=> !avail_q && state_q == SDC_OFF;
	endproperty
	a_reset: assert property (p_reset) else $error("power-down did not reset");

	property p_wake;
		@(posedge clk_i) disable iff (irst)
			state_q == SDC_SETTLE && $past(state_q) != SDC_SETTLE
				|-> $past(state_q) == SDC_WAKE && $past(cnt_q) == CW'(WAKE_CYC - 1);
	endproperty
	a_wake: assert property (p_wake) else $error("sampling before oscillator up");

	property p_drive_high;
		@(posedge clk_i) disable iff (irst)
			state_q != SDC_OFF && !ran_q |-> !dout_oe_n_o && dout_o;
	endproperty
	a_drive_high: assert property (p_drive_high) else $error("pin not high before result");

	property p_sat_hi;
		@(posedge clk_i) disable iff (irst)
			conv_tick && over |=> result_q == `SDC_MAX_CODE && err_q;
	endproperty
	a_sat_hi: assert property (p_sat_hi) else $error("no saturation high");

	property p_sat_lo;
		@(posedge clk_i) disable iff (irst)
			conv_tick && under |=> result_q == `SDC_MIN_CODE && err_q;
	endproperty
	a_sat_lo: assert property (p_sat_lo) else $error("no saturation low");

	property p_code;
		@(posedge clk_i) disable iff (irst)
			conv_tick && !over && !under
				|=> result_q == {~$past(src[`SDC_RES_W-1]), $past(src[`SDC_RES_W-2:0])} && !err_q;
	endproperty
	a_code: assert property (p_code) else $error("offset binary code wrong");

	property p_ready;
		@(posedge clk_i) disable iff (irst) conv_tick |=> avail_q && !dout_o && bit_q == '0;
	endproperty
	a_ready: assert property (p_ready) else $error("ready not low after update");

	property p_once;
		@(posedge clk_i) disable iff (irst) s_read_end |=> s_back_high;
	endproperty
	a_once: assert property (p_once) else $error("pin not high after read");

	property p_guard;
		@(posedge clk_i) disable iff (irst)
			state_q == SDC_RUN && cnt_q == CW'(CONV_CYC - 1) |-> !avail_q && dout_o;
	endproperty
	a_guard: assert property (p_guard) else $error("ready low during update");
endmodule

/* File: sdc_host_model.sv */
// Purpose: host side of the two-wire read link
// Assumes: link clock idles high, 400 ns period
// Notes:   a released pin shows the inverse of its last driven level
`timescale 1ns/1ns

module sdc_host_model (
	// link
	input  wire logic dout_i,
	input  wire logic dout_oe_n_i,
	output logic      sclk_o,
	output logic      pin_o
);
	logic last;

	initial begin
		sclk_o = 1'b1;
		last   = 1'b1;
	end

	always @* begin
		if (!dout_oe_n_i) begin
			last = dout_i;
		end
	end

	assign pin_o = dout_oe_n_i ? ~last : dout_i;

	// one word per result, stands still between frames
	task automatic read_word(input int nb, output logic [23:0] w);
		w = '0;
		#13;
		for (int i = 0; i < nb; i++) begin
			sclk_o = 1'b0;
			#300;
			sclk_o = 1'b1;
			w = {w[22:0], pin_o};
			#100;
		end
	endtask
endmodule

/* File: test_sigma_delta_conversion_control.sv */
// Purpose: self-checking bench of the conversion control block
// Assumes: shortened conversion, settling and wake counts
// Notes:   host reads are made by the partner model
`timescale 1ns/1ns

module test_sigma_delta_conversion_control;
	import sdc_pkg::*;
	localparam int CONV = 400;
	localparam int SETTLE = 1200;
	localparam int WAKE = 100;

	logic        clk_i;
	logic        rst_i;
	logic        pd_n;
	logic [17:0] sample_i;
	logic        valid;
	logic        ready;
	logic        sclk;
	logic        dout;
	logic        oe_n;
	logic        pin;
	sdc_state_t  state;
	int          failures;
	int          n_checks;
	int          vals[8] = '{0, -32768, 32767, 100, -1, 40000, -40000, 32768};

	sdc_conv_ctrl #(.CONV_CYC(CONV), .SETTLE_CYC(SETTLE), .WAKE_CYC(WAKE)) sdc_conv_ctrl_inst (
		.clk_i(clk_i), .rst_i(rst_i), .power_down_reset_n_i(pd_n), .sample_i(sample_i),
		.sample_valid_i(valid), .sample_ready_o(ready), .sclk_i(sclk), .dout_o(dout),
		.dout_oe_n_o(oe_n), .state_o(state));

	sdc_host_model sdc_host_model_inst (
		.dout_i(dout), .dout_oe_n_i(oe_n), .sclk_o(sclk), .pin_o(pin));

	// ****************************************
	// helpers
	// ****************************************
	task automatic end_of_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input int tol);
		n_checks++;
		if ($isunknown(got) || got + tol < exp || got > exp + tol) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_lvl(input logic lvl, input int lim, output int n);
		n = 0;
		while (pin !== lvl && n < lim) begin
			@(negedge clk_i);
			n++;
		end
		if (pin !== lvl) begin
			chk(24'(pin), 24'(lvl), 0);
			end_of_test();
		end
	endtask

	function automatic logic [23:0] exp_word(input int v);
		logic err;
		logic [15:0] c;
		err = v > 32767 || v < -32768;
		c = v > 32767 ? 16'hffff : v < -32768 ? 16'h0000 : 16'(v + 32768);
		return {c, 2'h0, err, 2'h2, 3'h5};
	endfunction

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_first_result();
		int n;
		int n1;
		int n2;
		n = 0;
		while (state !== SDC_WAKE && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		if (state !== SDC_WAKE) begin
			chk(24'(state), 24'(SDC_WAKE), 0);
			end_of_test();
		end
		@(negedge clk_i);
		chk(24'(oe_n), 24'h0, 0);
		chk(24'(pin), 24'h1, 0);
		wait_lvl(1'b0, 3 * SETTLE, n);
		chk(24'(n), 24'(WAKE + SETTLE), 2);
		wait_lvl(1'b1, CONV, n1);
		wait_lvl(1'b0, CONV, n2);
		chk(24'(n1 + n2), 24'(CONV), 1);
		chk(24'(n2), 24'h4, 0);
	endtask

	task automatic t_codes();
		int n;
		logic [23:0] w;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			#2;
			sample_i = 18'(vals[i]);
			valid = 1'b1;
			@(negedge clk_i);
			chk(24'(ready), 24'h1, 0);
		end
		@(posedge clk_i);
		#2;
		valid = 1'b0;
		@(negedge clk_i);
		chk(24'(ready), 24'h0, 0);
		for (int i = 0; i < 8; i++) begin
			wait_lvl(1'b1, CONV, n);
			wait_lvl(1'b0, CONV, n);
			sdc_host_model_inst.read_word(24, w);
			chk(w, exp_word(vals[i]), 0);
			repeat (12) @(negedge clk_i);
			chk(24'(pin), 24'h1, 0);
			sdc_host_model_inst.read_word(8, w);
			chk(w, 24'hff, 0);
		end
		chk(24'(ready), 24'h1, 0);
	endtask

	task automatic t_power_down();
		logic [23:0] w;
		@(posedge clk_i);
		#2;
		sample_i = 18'(vals[3]);
		valid = 1'b1;
		@(posedge clk_i);
		#2;
		valid = 1'b0;
		pd_n = 1'b0;
		repeat (4) @(negedge clk_i);
		chk(24'(oe_n), 24'h1, 0);
		chk(24'(state), 24'(SDC_OFF), 0);
		@(posedge clk_i);
		#2;
		pd_n = 1'b1;
		t_first_result();
		sdc_host_model_inst.read_word(24, w);
		chk(w, exp_word(0), 0);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	initial begin
		#2000000;
		failures++;
		end_of_test();
	end

	initial begin
		failures = 0;
		n_checks = 0;
		rst_i = 1'b1;
		pd_n = 1'b1;
		sample_i = '0;
		valid = 1'b0;
		repeat (5) @(negedge clk_i);
		chk(24'(oe_n), 24'h1, 0);
		@(posedge clk_i);
		#2;
		rst_i = 1'b0;
		t_first_result();
		t_codes();
		t_power_down();
		end_of_test();
	end
endmodule
